// File: pcg_pkg.sv
// Purpose: constants for the pad configuration and pad interrupt unit
// Assumes: APB slave, 32-bit data, 12-bit byte address
// Notes: one configuration word per pad, packed bit vectors per group
// Notes on behaviour
// - the unit controls input and output paths of all 190 pads
// - each pad has a four-bit function select, up to sixteen functions
// - every pad can be a plain input or a plain output; all but high-speed pads can be both
// - per-pad interrupt on rising, falling or both input edges
// - interrupt lines 0-6 and 8-14; lines 7 and 15 reserved
// - interrupt word n covers pads 32n to 32n+31, n from 0 to 6
// - per pad bit: enable, status, clear and force registers
// - a second identical interrupt register set for priority handling
// - high-speed pads give no input readback while driving as output
// - any pad can carry a serial manager or display chip enable
// - memory controller chip enables only on pads listing them
// - drive mode push-pull, open drain or tri-stated push-pull
// - high-speed pads: eight strengths, no slew, only fixed 50k pulls
// - after boot pad 28 carries the serial trace output at 1 Mbaud
package pcg_pkg;
   localparam int NPAD = 190;
   localparam int NWORD = 7;
   localparam int NBIT = 224;
   localparam int CFG_W = 20;
   localparam int AW = 12;
   localparam int NSERCE = 9;
   localparam int NMEMCE = 8;
   // register byte offsets
   localparam logic [11:0] OFF_CFG = 12'h000;
   localparam logic [11:0] OFF_CFG_END = 12'h2F8;
   localparam logic [11:0] OFF_DOUT = 12'h300;
   localparam logic [11:0] OFF_OE = 12'h320;
   localparam logic [11:0] OFF_DIN = 12'h340;
   localparam logic [11:0] OFF_EN0 = 12'h400;
   localparam logic [11:0] OFF_STAT0 = 12'h420;
   localparam logic [11:0] OFF_CLR0 = 12'h440;
   localparam logic [11:0] OFF_SET0 = 12'h460;
   localparam logic [11:0] OFF_EN1 = 12'h480;
   localparam logic [11:0] OFF_STAT1 = 12'h4A0;
   localparam logic [11:0] OFF_CLR1 = 12'h4C0;
   localparam logic [11:0] OFF_SET1 = 12'h4E0;
   localparam logic [11:0] GRP_MASK = 12'hFE0;
   // pad configuration word fields
   localparam int FN_LSB = 0;
   localparam int PAD_INPUT_ENABLE_BIT = 4;
   localparam int DRV_LSB = 5;
   localparam int STR_LSB = 7;
   localparam int SLEW_BIT = 10;
   localparam int PULL_LSB = 11;
   localparam int EDGE_RISE_BIT = 14;
   localparam int EDGE_FALL_BIT = 15;
   localparam int CE_LSB = 16;
   // function select codes
   localparam logic [3:0] FN_TRACE = 4'h0;
   localparam logic [3:0] FN_GPIO = 4'h3;
   localparam logic [3:0] FN_SERCE = 4'h7;
   localparam logic [3:0] FN_MEMCE = 4'h9;
   // drive modes
   localparam logic [1:0] DRV_PP = 2'h0;
   localparam logic [1:0] DRV_OD = 2'h1;
   localparam logic [1:0] DRV_TS = 2'h2;
   // pull codes: 3 and above are the other pull-up values
   localparam logic [2:0] PULL_DN_50K = 3'h1;
   localparam logic [2:0] PULL_UP_50K = 3'h2;
   // reset values and boot trace pad
   localparam int BOOT_PAD = 28;
   localparam int BOOT_BAUD = 1000000;
   localparam logic [CFG_W-1:0] CFG_RST = 20'h00043;
   localparam logic [CFG_W-1:0] CFG_RST_BOOT = 20'h00000;

   // pads with high-speed drivers
   function automatic logic [NPAD-1:0] hs_mask();
      logic [NPAD-1:0] m;
      m = '0;
      for (int i = 0; i < NPAD; i++) begin
         m[i] = (i >= 37 && i <= 45) || (i >= 64 && i <= 73) ||
                (i >= 105 && i <= 113) || (i >= 115 && i <= 124) ||
                (i >= 142 && i <= 147);
      end
      return m;
   endfunction

   // pads that list a memory controller chip enable function
   function automatic logic [NPAD-1:0] memce_mask();
      logic [NPAD-1:0] m;
      m = '0;
      for (int i = 0; i < NPAD; i++) begin
         m[i] = (i == 7) || (i == 10) || (i == 24) || (i == 27) ||
                (i == 33) || (i == 36) || (i == 49) || (i >= 52 && i <= 54);
      end
      return m;
   endfunction
endpackage

// File: pcg_edge.sv
// Purpose: two-stage synchroniser and edge detector for pad inputs
// Assumes: one clock, asynchronous active-low reset
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module pcg_edge #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // raw and synchronised levels, edge pulses
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] level_o,
   output logic [W-1:0] rise_o,
   output logic [W-1:0] fall_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   logic [W-1:0] last_ff;

   // synchroniser, then one delay stage for edge compare
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '0;
         sync_ff <= '0;
         last_ff <= '0;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   // each edge yields one pulse only
   assign level_o = sync_ff;
   assign rise_o = sync_ff & ~last_ff;
   assign fall_o = ~sync_ff & last_ff;
endmodule

// File: pcg_top.sv
// Purpose: pad function routing, drive control and pad interrupts
// Assumes: APB slave with one wait state, inputs synchronous except pads
// Notes: pad outputs lag configuration by one clock
`timescale 1ns/1ps
module pcg_top
   import pcg_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pads
   input wire logic [NPAD-1:0] pad_i,
   output logic [NPAD-1:0] pad_o,
   output logic [NPAD-1:0] pad_oe,
   output logic [NPAD-1:0] pad_pullup,
   output logic [NPAD-1:0] pad_pulldown,
   // peripheral side
   input wire logic [NPAD-1:0] periph_o,
   input wire logic [NPAD-1:0] periph_oe,
   input wire logic [NSERCE-1:0] serial_chip_enable_b,
   input wire logic [NMEMCE-1:0] memctl_chip_enable_b,
   output logic [NPAD-1:0] pad_input_enable,
   // interrupt lines
   output logic [15:0] irq_line
);
   localparam logic [NPAD-1:0] HS = hs_mask();
   localparam logic [NPAD-1:0] MCE = memce_mask();

   logic [CFG_W-1:0] cfg_ff [NPAD];
   logic [NBIT-1:0] dout_ff, oe_ff, en0_ff, stat0_ff, en1_ff, stat1_ff;
   logic [NBIT-1:0] hit, clr0, set0, clr1, set1, din_w;
   logic [NPAD-1:0] lvl, rise, fall, nxt_v, nxt_e;
   logic [NPAD-1:0] pad_o_ff, pad_oe_ff, pu_ff, pd_ff, pin_ff;
   logic [15:0] irq_ff;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, pslverr_ff, nxt_err;
   logic acc, wr_en, req0;
   logic [11:0] grp;
   int wi, ci;

   // apb handshake: answer one cycle into the access phase
   assign acc = psel && penable;
   assign wr_en = acc && pwrite && pready_ff && paddr[1:0] == 2'h0;
   assign grp = paddr & GRP_MASK;
   assign wi = int'(paddr[4:2]);
   assign ci = int'(paddr[9:2]);
   assign din_w = NBIT'(pin_ff);

   // synchronise and edge-detect every pad
   pcg_edge #(
      .W(NPAD)
   ) u_edge (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .async_i(pad_i),
      .level_o(lvl),
      .rise_o(rise),
      .fall_o(fall)
   );

   // qualifying edges, words above the last pad stay zero
   always_comb begin
      hit = '0;
      for (int p = 0; p < NPAD; p++) begin
         hit[p] = (rise[p] && cfg_ff[p][EDGE_RISE_BIT]) ||
                  (fall[p] && cfg_ff[p][EDGE_FALL_BIT]);
      end
   end

   // write-one masks for clear and force, one word at a time
   always_comb begin
      clr0 = '0;
      set0 = '0;
      clr1 = '0;
      set1 = '0;
      if (wr_en && wi < NWORD) begin
         if (grp == OFF_CLR0) clr0[wi*32 +: 32] = pwdata;
         if (grp == OFF_SET0) set0[wi*32 +: 32] = pwdata;
         if (grp == OFF_CLR1) clr1[wi*32 +: 32] = pwdata;
         if (grp == OFF_SET1) set1[wi*32 +: 32] = pwdata;
      end
   end

   // read mux and unmapped-address error
   always_comb begin
      nxt_prdata = '0;
      nxt_err = 1'b0;
      if (paddr[1:0] != 2'h0) begin
         nxt_err = 1'b1;
      end else if (paddr < OFF_CFG_END) begin
         if (ci < NPAD) begin
            nxt_prdata[CFG_W-1:0] = cfg_ff[ci];
         end else begin
            nxt_err = 1'b1;
         end
      end else if (wi >= NWORD) begin
         nxt_err = 1'b1;
      end else begin
         unique case (grp)
            OFF_DOUT: nxt_prdata = dout_ff[wi*32 +: 32];
            OFF_OE: nxt_prdata = oe_ff[wi*32 +: 32];
            OFF_DIN: nxt_prdata = din_w[wi*32 +: 32];
            OFF_EN0: nxt_prdata = en0_ff[wi*32 +: 32];
            OFF_STAT0: nxt_prdata = stat0_ff[wi*32 +: 32];
            OFF_EN1: nxt_prdata = en1_ff[wi*32 +: 32];
            OFF_STAT1: nxt_prdata = stat1_ff[wi*32 +: 32];
            OFF_CLR0, OFF_SET0, OFF_CLR1, OFF_SET1: nxt_prdata = '0;
            default: nxt_err = 1'b1;
         endcase
      end
   end

   // bus answer registers
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= '0;
      end else begin
         pready_ff <= acc && !pready_ff;
         pslverr_ff <= acc && !pready_ff && nxt_err;
         prdata_ff <= (acc && !pready_ff && !pwrite) ? nxt_prdata : '0;
      end
   end

   // pad configuration words; high-speed pads clamp slew and pull
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         for (int p = 0; p < NPAD; p++) begin
            cfg_ff[p] <= (p == BOOT_PAD) ? CFG_RST_BOOT : CFG_RST;
         end
      end else if (wr_en && paddr < OFF_CFG_END && ci < NPAD) begin
         cfg_ff[ci] <= pwdata[CFG_W-1:0];
         if (HS[ci]) begin
            cfg_ff[ci][SLEW_BIT] <= 1'b0;
            if (pwdata[PULL_LSB +: 3] > PULL_UP_50K) begin
               cfg_ff[ci][PULL_LSB +: 3] <= 3'h0;
            end
         end
      end
   end

   // plain output data and output enable
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         dout_ff <= '0;
         oe_ff <= '0;
      end else if (wr_en && wi < NWORD) begin
         if (grp == OFF_DOUT) dout_ff[wi*32 +: 32] <= pwdata;
         if (grp == OFF_OE) oe_ff[wi*32 +: 32] <= pwdata;
      end
   end

   // interrupt enables for both register sets
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         en0_ff <= '0;
         en1_ff <= '0;
      end else if (wr_en && wi < NWORD) begin
         if (grp == OFF_EN0) en0_ff[wi*32 +: 32] <= pwdata;
         if (grp == OFF_EN1) en1_ff[wi*32 +: 32] <= pwdata;
      end
   end

   // sticky status: an edge or force in the clear cycle wins
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         stat0_ff <= '0;
         stat1_ff <= '0;
      end else begin
         stat0_ff <= ((stat0_ff & ~clr0) | hit | set0) &
                     NBIT'({NPAD{1'b1}});
         stat1_ff <= ((stat1_ff & ~clr1) | hit | set1) &
                     NBIT'({NPAD{1'b1}});
      end
   end

   // one line per 32-pad word; lines 7 and 15 held low
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         irq_ff <= '0;
      end else begin
         irq_ff <= '0;
         for (int w = 0; w < NWORD; w++) begin
            irq_ff[w] <= |(stat0_ff[w*32 +: 32] & en0_ff[w*32 +: 32]);
            irq_ff[w+8] <= |(stat1_ff[w*32 +: 32] & en1_ff[w*32 +: 32]);
         end
      end
   end

   // function select per pad: value and enable ahead of drive mode
   always_comb begin
      logic [3:0] ce;
      ce = '0;
      nxt_v = periph_o;
      nxt_e = periph_oe;
      for (int p = 0; p < NPAD; p++) begin
         ce = cfg_ff[p][CE_LSB +: 4];
         unique case (cfg_ff[p][FN_LSB +: 4])
            FN_GPIO: begin
               nxt_v[p] = dout_ff[p];
               nxt_e[p] = oe_ff[p] || cfg_ff[p][DRV_LSB +: 2] == DRV_PP;
            end
            FN_SERCE: begin
               nxt_v[p] = (int'(ce) < NSERCE) ?
                          serial_chip_enable_b[ce] : 1'b1;
               nxt_e[p] = 1'b1;
            end
            FN_MEMCE: begin
               nxt_v[p] = memctl_chip_enable_b[ce[2:0]];
               nxt_e[p] = MCE[p];
            end
            default: begin
               nxt_v[p] = periph_o[p];
               nxt_e[p] = periph_oe[p];
            end
         endcase
      end
   end

   // drive mode and pulls for every pad
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pad_o_ff <= '0;
         pad_oe_ff <= '0;
         pu_ff <= '0;
         pd_ff <= '0;
      end else begin
         for (int p = 0; p < NPAD; p++) begin
            unique case (cfg_ff[p][DRV_LSB +: 2])
               DRV_OD: begin
                  pad_o_ff[p] <= 1'b0;
                  pad_oe_ff[p] <= nxt_e[p] && !nxt_v[p];
               end
               default: begin
                  pad_o_ff[p] <= nxt_v[p];
                  pad_oe_ff[p] <= nxt_e[p];
               end
            endcase
            pd_ff[p] <= cfg_ff[p][PULL_LSB +: 3] == PULL_DN_50K;
            pu_ff[p] <= cfg_ff[p][PULL_LSB +: 3] >= PULL_UP_50K;
         end
      end
   end

   // input path; high-speed pads go quiet while driving
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_ff <= '0;
      end else begin
         for (int p = 0; p < NPAD; p++) begin
            pin_ff[p] <= lvl[p] && cfg_ff[p][PAD_INPUT_ENABLE_BIT] &&
                         !(HS[p] && pad_oe_ff[p]);
         end
      end
   end

   // outputs straight from flip-flops
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign pad_o = pad_o_ff;
   assign pad_oe = pad_oe_ff;
   assign pad_pullup = pu_ff;
   assign pad_pulldown = pd_ff;
   assign pad_input_enable = pin_ff;
   assign irq_line = irq_ff;

   property p_edge_sets;
      @(posedge sys_clk) disable iff (!rst_b)
      (rise[6] && cfg_ff[6][EDGE_RISE_BIT]) |=> stat0_ff[6] && stat1_ff[6];
   endproperty
   a_edge_sets: assert property (p_edge_sets)
      else $error("rising edge did not set status");

   property p_clear;
      @(posedge sys_clk) disable iff (!rst_b)
      (wr_en && paddr == OFF_CLR0 && pwdata[6] && !hit[6]) |=> !stat0_ff[6];
   endproperty
   a_clear: assert property (p_clear)
      else $error("clear write left status set");

   property p_force;
      @(posedge sys_clk) disable iff (!rst_b)
      (wr_en && paddr == OFF_SET1 && pwdata[1]) |=> stat1_ff[1];
   endproperty
   a_force: assert property (p_force)
      else $error("force write did not set status");

   // word 0 request level, one clock ahead of its line
   assign req0 = |(stat0_ff[31:0] & en0_ff[31:0]);

   property p_irq_line;
      @(posedge sys_clk) disable iff (!rst_b)
      ##1 irq_ff[0] == $past(req0);
   endproperty
   a_irq_line: assert property (p_irq_line)
      else $error("interrupt line disagrees with status and enable");

   property p_reserved;
      @(posedge sys_clk) disable iff (!rst_b)
      !irq_ff[7] && !irq_ff[15];
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved interrupt line raised");

   property p_hs_quiet;
      @(posedge sys_clk) disable iff (!rst_b)
      pad_oe_ff[40] |=> !pin_ff[40];
   endproperty
   a_hs_quiet: assert property (p_hs_quiet)
      else $error("high-speed pad read back while driving");

   property p_open_drain;
      @(posedge sys_clk) disable iff (!rst_b)
      (cfg_ff[5][DRV_LSB +: 2] == DRV_OD) |=> !pad_o_ff[5];
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("open-drain pad drove high");

   property p_hs_slew;
      @(posedge sys_clk) disable iff (!rst_b)
      !cfg_ff[40][SLEW_BIT] && cfg_ff[40][PULL_LSB +: 3] <= PULL_UP_50K;
   endproperty
   a_hs_slew: assert property (p_hs_slew)
      else $error("high-speed pad holds slew or wide pull");

   property p_answer;
      @(posedge sys_clk) disable iff (!rst_b)
      (acc && !pready_ff) |=> pready_ff ##1 !pready_ff;
   endproperty
   a_answer: assert property (p_answer)
      else $error("bus answer not exactly one cycle late");
endmodule

// File: pcg_pads.sv
// Purpose: external pad model facing the pad unit
// Assumes: one bench-driven source per pad, enabled by ext_en
// Notes: a floating pad with no pull flips every clock
`timescale 1ns/1ps
module pcg_pads
   import pcg_pkg::*;
(
   // clock
   input wire logic sys_clk,
   // drive from the unit
   input wire logic [NPAD-1:0] pad_o,
   input wire logic [NPAD-1:0] pad_oe,
   input wire logic [NPAD-1:0] pad_pullup,
   input wire logic [NPAD-1:0] pad_pulldown,
   // outside source
   input wire logic [NPAD-1:0] ext_val,
   input wire logic [NPAD-1:0] ext_en,
   // resolved level back to the unit
   output logic [NPAD-1:0] pad_i
);
   logic [NPAD-1:0] last_ff;

   // keep last level so a floating pad never looks stable
   always_ff @(posedge sys_clk) begin
      last_ff <= pad_i;
   end

   // unit drive is strong, outside source weak, pulls weakest
   always_comb begin
      for (int i = 0; i < NPAD; i++) begin
         if (pad_oe[i]) begin
            pad_i[i] = pad_o[i];
         end else if (ext_en[i]) begin
            pad_i[i] = ext_val[i];
         end else if (pad_pullup[i]) begin
            pad_i[i] = 1'b1;
         end else if (pad_pulldown[i]) begin
            pad_i[i] = 1'b0;
         end else begin
            pad_i[i] = ~last_ff[i];
         end
      end
   end
endmodule

// File: pad_config_gpio_interrupts_test.sv
// Purpose: self-checking bench for the pad unit over apb
// Assumes: one wait state apb slave, pad outputs lag config by a clock
// Notes: waits after pad edges cover the input synchroniser
`timescale 1ns/1ps
module pad_config_gpio_interrupts_test
   import pcg_pkg::*;
;
   logic sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic [AW-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NPAD-1:0] pad_i, pad_o, pad_oe, pad_pullup, pad_pulldown;
   logic [NPAD-1:0] periph_o, periph_oe, pad_input_enable, ext_val, ext_en;
   logic [NSERCE-1:0] serial_chip_enable_b;
   logic [NMEMCE-1:0] memctl_chip_enable_b;
   logic [15:0] irq_line;
   int fails = 0;
   int tests_run = 0;

   pcg_top uut (.sys_clk(sys_clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_i(pad_i),
      .pad_o(pad_o), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
      .pad_pulldown(pad_pulldown), .periph_o(periph_o),
      .periph_oe(periph_oe), .serial_chip_enable_b(serial_chip_enable_b),
      .memctl_chip_enable_b(memctl_chip_enable_b),
      .pad_input_enable(pad_input_enable), .irq_line(irq_line));

   pcg_pads pads (.sys_clk(sys_clk), .pad_o(pad_o), .pad_oe(pad_oe),
      .pad_pullup(pad_pullup), .pad_pulldown(pad_pulldown),
      .ext_val(ext_val), .ext_en(ext_en), .pad_i(pad_i));

   // 20 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end

   task automatic give_verdict();
      if (fails == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // one apb transfer; an idle edge after it avoids re-driving psel
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // no fixed wait assumed; only the hang guard ends a stuck wait
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   function automatic logic [11:0] ca(input int p);
      return OFF_CFG + 12'(4 * p);
   endfunction

   // hang guard, far beyond the expected run
   initial begin
      repeat (20000) @(posedge sys_clk);
      fails++;
      give_verdict();
   end

   initial begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      periph_o = '0;
      periph_oe = '0;
      serial_chip_enable_b = '1;
      memctl_chip_enable_b = '1;
      ext_val = '0;
      ext_en = '1;
      tick(6);
      rst_b <= 1'b1;
      tick(1);
      // reset configuration and boot trace pad
      rdc(ca(0), 32'(CFG_RST));
      rdc(ca(BOOT_PAD), 32'(CFG_RST_BOOT));
      periph_oe[BOOT_PAD] <= 1'b1;
      periph_o[BOOT_PAD] <= 1'b1;
      tick(3);
      chk(32'({pad_oe[BOOT_PAD], pad_o[BOOT_PAD]}), 32'h3);
      // pad index past the last pad, group word 7 and word 6
      apb(1'b0, OFF_CFG_END, 32'h0);
      chk(32'({rd, err}), 32'h1);
      apb(1'b0, OFF_EN0 + 12'h01C, 32'h0);
      chk(32'(err), 32'h1);
      apb(1'b0, OFF_EN0 + 12'h018, 32'h0);
      chk(32'(err), 32'h0);
      // tri-stated push-pull, push-pull, open drain on pad 5
      wr(OFF_DOUT, 32'h20);
      wr(OFF_OE, 32'h20);
      tick(2);
      chk(32'({pad_oe[5], pad_o[5]}), 32'h3);
      wr(OFF_OE, 32'h0);
      tick(2);
      chk(32'(pad_oe[5]), 32'h0);
      wr(ca(5), 32'h3);
      tick(2);
      chk(32'({pad_oe[5], pad_o[5]}), 32'h3);
      wr(ca(5), 32'h33);
      tick(2);
      chk(32'(pad_oe[5]), 32'h0);
      wr(OFF_OE, 32'h20);
      wr(OFF_DOUT, 32'h0);
      tick(2);
      chk(32'({pad_oe[5], pad_o[5]}), 32'h2);
      // input path, outside source drives pad 5 high
      wr(OFF_DOUT, 32'h20);
      ext_val[5] <= 1'b1;
      tick(5);
      rdc(OFF_DIN, 32'h20);
      chk(32'(pad_input_enable[5]), 32'h1);
      // readback while driving: high-speed pad 40 against pad 5
      wr(ca(5), 32'h13);
      wr(ca(40), 32'h13);
      wr(OFF_DOUT + 12'h4, 32'h100);
      tick(5);
      rdc(OFF_DIN + 12'h4, 32'h0);
      rdc(OFF_DIN, 32'h20);
      // slew and wide pulls dropped on high-speed pads only
      wr(ca(40), 32'h2FC3);
      rdc(ca(40), 32'h3C3);
      wr(ca(6), 32'h2C43);
      rdc(ca(6), 32'h2C43);
      tick(2);
      chk(32'(pad_pullup[6]), 32'h1);
      // rising edge interrupt on pad 6, then clear
      wr(ca(6), 32'h4053);
      wr(OFF_EN0, 32'h40);
      ext_val[6] <= 1'b1;
      tick(8);
      rdc(OFF_STAT0, 32'h40);
      chk(32'(irq_line), 32'h1);
      wr(OFF_CLR0, 32'h40);
      tick(2);
      chk(32'(irq_line), 32'h0);
      rdc(OFF_CLR0, 32'h0);
      ext_val[6] <= 1'b0;
      tick(8);
      rdc(OFF_STAT0, 32'h0);
      // both edges selected
      wr(ca(6), 32'hC053);
      ext_val[6] <= 1'b1;
      tick(8);
      rdc(OFF_STAT0, 32'h40);
      wr(OFF_CLR0, 32'h40);
      ext_val[6] <= 1'b0;
      tick(8);
      rdc(OFF_STAT0, 32'h40);
      wr(OFF_CLR0, 32'h40);
      tick(8);
      rdc(OFF_STAT0, 32'h0);
      // force with enable off, status is read-only
      wr(OFF_EN0, 32'h0);
      wr(OFF_SET0, 32'h40);
      wr(OFF_STAT0, 32'h0);
      rdc(OFF_STAT0, 32'h40);
      chk(32'(irq_line), 32'h0);
      wr(OFF_CLR0, 32'h40);
      // groups 0 to 5 in both sets, reserved lines stay low
      for (int n = 0; n < 6; n++) begin
         wr(OFF_EN0 + 12'(4 * n), 32'h1);
         wr(OFF_SET0 + 12'(4 * n), 32'h1);
         wr(OFF_EN1 + 12'(4 * n), 32'h2);
         wr(OFF_SET1 + 12'(4 * n), 32'h2);
      end
      tick(2);
      chk(32'(irq_line), 32'h3F3F);
      rdc(OFF_STAT1 + 12'hC, 32'h2);
      wr(OFF_CLR0 + 12'hC, 32'h1);
      tick(2);
      chk(32'(irq_line), 32'h3F37);
      // serial manager and display chip enables on pad 12
      for (int k = 0; k < NSERCE; k++) begin
         wr(ca(12), 32'h7 | (32'(k) << CE_LSB));
         serial_chip_enable_b <= ~(9'(1) << k);
         tick(3);
         chk(32'({pad_oe[12], pad_o[12]}), 32'h2);
      end
      // memory controller chip enables only where listed
      for (int k = 0; k < NMEMCE; k++) begin
         wr(ca(7), 32'h9 | (32'(k) << CE_LSB));
         memctl_chip_enable_b <= ~(8'(1) << k);
         tick(3);
         chk(32'({pad_oe[7], pad_o[7]}), 32'h2);
      end
      wr(ca(8), 32'h809);
      tick(3);
      chk(32'(pad_oe[8]), 32'h0);
      chk(32'(pad_pulldown[8]), 32'h1);
      // peripheral functions route periph signals on pad 13
      periph_o[13] <= 1'b1;
      periph_oe[13] <= 1'b1;
      for (int f = 0; f < 16; f++) begin
         if (f != 3 && f != 7 && f != 9) begin
            wr(ca(13), 32'(f));
            tick(3);
            chk(32'({pad_oe[13], pad_o[13]}), 32'h3);
         end
      end
      give_verdict();
   end
endmodule
